// ### rtl/gyro_filter_and_frame_queue.v
`timescale 1ns/10ps
`default_nettype none
`include "gyro_queue_defines.vh"
module gyro_filter_and_frame_queue #(
  parameter BASE_DIV = `GQ_BASE_DIV,
  parameter QUEUE_BYTES = `GQ_QUEUE_BYTES,
  parameter STAGE_DEPTH = `GQ_STAGE_DEPTH
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire power_normal_i,
  input wire [2:0] filter_mode_i,
  input wire [3:0] odr_sel_i,
  input wire [1:0] gyro_range_i,
  input wire [2:0] queue_decimation_i,
  input wire prefilt_sel_i,
  input wire header_mode_i,
  input wire queue_gyro_en_i,
  input wire sensortime_frame_en_i,
  input wire pin_tag_en_i,
  input wire interrupt_line_1_i,
  input wire interrupt_line_2_i,
  input wire [47:0] raw_sample_i,
  input wire [23:0] sensor_time_i,
  input wire queue_flush_i,
  input wire burst_active_i,
  input wire burst_start_i,
  input wire rd_req_i,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  output reg [47:0] sample_o,
  output reg sample_valid_o,
  output reg [3:0] err_code_o,
  output reg [`GQ_CNT_W-1:0] fill_count_o,
  output reg overflow_o,
  output wire stage_ready_o
);
  localparam RD_SKIP_HDR = 3'd0;
  localparam RD_SKIP_CNT = 3'd1;
  localparam RD_DATA = 3'd2;
  localparam RD_TIME_HDR = 3'd3;
  localparam RD_TIME_B0 = 3'd4;
  localparam RD_TIME_B1 = 3'd5;
  localparam RD_TIME_B2 = 3'd6;
  localparam RD_END = 3'd7;

  // frame length from its first byte
  function [3:0] frame_len;
    input hdr_mode;
    input [7:0] first;
    begin
      if (!hdr_mode)
        frame_len = `GQ_LEN_HEADERLESS;
      else if (first[7:6] == `GQ_KIND_CONTROL)
        frame_len = `GQ_LEN_CONTROL;
      else
        frame_len = `GQ_LEN_REGULAR;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // configuration check
  wire mode_ok = (filter_mode_i == `GQ_MODE_NORMAL) | (filter_mode_i == `GQ_MODE_TWOFOLD) |
    (filter_mode_i == `GQ_MODE_FOURFOLD);
  wire odr_ok = (odr_sel_i >= `GQ_ODR_MIN) & (odr_sel_i <= `GQ_ODR_MAX);
  wire cfg_ok = mode_ok & odr_ok;
  wire run = power_normal_i & cfg_ok;

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
      err_code_o <= `GQ_ERR_NONE;
    else
      err_code_o <= cfg_ok ? `GQ_ERR_NONE : `GQ_ERR_CONF;
  end

  ////////////////////////////////////////////////////////////////////
  // 6400 Hz base rate and history of raw samples
  wire base_tick;
  rate_divider #(
    .DIV(BASE_DIV),
    .CW(16)
  ) u_base (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .tick_o(base_tick)
  );

  wire raw_tick = base_tick & run;
  reg [47:0] hist_q [0:3];
  reg [7:0] odr_cnt_q;
  // divide ratio is 2^(14-code): 3200 Hz -> 2, 25 Hz -> 256
  wire [3:0] odr_shift = `GQ_ODR_BASE - odr_sel_i;
  wire [8:0] odr_ratio = 9'd1 << odr_shift;
  wire odr_tick = raw_tick & ({1'b0, odr_cnt_q} == odr_ratio - 9'd1);

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
      odr_cnt_q <= 8'h00;
    else if (!run)
      odr_cnt_q <= 8'h00; // sleep restarts the phase
    else if (raw_tick)
      odr_cnt_q <= odr_tick ? 8'h00 : odr_cnt_q + 8'h01;
  end

  always @(posedge sys_clk_i)
  begin
    if (raw_tick)
    begin
      hist_q[0] <= raw_sample_i;
      hist_q[1] <= hist_q[0];
      hist_q[2] <= hist_q[1];
      hist_q[3] <= hist_q[2];
    end
  end

  // averaging over the oversampling window, per axis
  wire [47:0] filt;
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1)
    begin : g_axis
      wire signed [15:0] s0 = hist_q[0][16*ax+15:16*ax];
      wire signed [15:0] s1 = hist_q[1][16*ax+15:16*ax];
      wire signed [15:0] s2 = hist_q[2][16*ax+15:16*ax];
      wire signed [15:0] s3 = hist_q[3][16*ax+15:16*ax];
      wire signed [16:0] sum2 = s0 + s1;
      wire signed [17:0] sum4 = s0 + s1 + s2 + s3;
      assign filt[16*ax+15:16*ax] =
        (filter_mode_i == `GQ_MODE_TWOFOLD) ? sum2[16:1] :
        (filter_mode_i == `GQ_MODE_FOURFOLD) ? sum4[17:2] : s0;
    end
  endgenerate

  // sample register updates at the output rate
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sample_o <= 48'h0;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= odr_tick;
      if (odr_tick)
        sample_o <= filt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // queue rate and decimation
  wire q_src_tick = prefilt_sel_i ? raw_tick : odr_tick;
  reg [6:0] dec_cnt_q;
  wire [6:0] dec_mask = (7'h01 << queue_decimation_i) - 7'h01;
  wire q_tick = q_src_tick & ((dec_cnt_q & dec_mask) == 7'h00) & queue_gyro_en_i;
  wire [47:0] q_data = prefilt_sel_i ? raw_sample_i : filt; // history lags one tick

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
      dec_cnt_q <= 7'h00;
    else if (q_src_tick)
      dec_cnt_q <= dec_cnt_q + 7'h01; // kept samples pass untouched
  end

  ////////////////////////////////////////////////////////////////////
  // frame assembler into the staging fifo
  reg [11:0] cfg_q;
  reg hdr_q;
  reg cfg_pend_q;
  reg range_ch_q;
  reg conf_ch_q;
  reg data_pend_q;
  reg [55:0] data_buf_q;
  reg [3:0] data_len_q;
  reg [55:0] sh_q;
  reg [3:0] sh_left_q;
  reg sh_first_q;
  wire [11:0] cfg_now = {gyro_range_i, filter_mode_i, odr_sel_i, queue_decimation_i[1:0],
    prefilt_sel_i ^ queue_decimation_i[2]};
  wire cfg_diff = (cfg_now != cfg_q);
  wire auto_flush = queue_flush_i | (hdr_q != header_mode_i);
  wire st_ready;
  wire [1:0] tag = pin_tag_en_i ? {interrupt_line_2_i, interrupt_line_1_i} : 2'b00;
  wire [7:0] reg_hdr = {`GQ_KIND_REGULAR, `GQ_PARAM_GYRO, tag};
  wire push = (sh_left_q != 4'h0);

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cfg_q <= 12'h0;
      hdr_q <= 1'b0;
      cfg_pend_q <= 1'b0;
      range_ch_q <= 1'b0;
      conf_ch_q <= 1'b0;
      data_pend_q <= 1'b0;
      data_buf_q <= 56'h0;
      data_len_q <= 4'h0;
      sh_q <= 56'h0;
      sh_left_q <= 4'h0;
      sh_first_q <= 1'b0;
    end
    else
    begin
      hdr_q <= header_mode_i;
      cfg_q <= cfg_now;
      if (cfg_diff & header_mode_i)
      begin
        cfg_pend_q <= 1'b1;
        range_ch_q <= range_ch_q | (cfg_now[11:10] != cfg_q[11:10]);
        conf_ch_q <= conf_ch_q | (cfg_now[9:0] != cfg_q[9:0]);
      end
      if (q_tick)
      begin
        data_pend_q <= 1'b1;
        if (header_mode_i)
        begin
          data_buf_q <= {q_data, reg_hdr};
          data_len_q <= `GQ_LEN_REGULAR;
        end
        else
        begin
          data_buf_q <= {8'h00, q_data};
          data_len_q <= `GQ_LEN_HEADERLESS;
        end
      end
      if (auto_flush)
      begin
        sh_left_q <= 4'h0;
        data_pend_q <= 1'b0;
      end
      else if (push)
      begin
        if (st_ready)
        begin
          sh_q <= {8'h00, sh_q[55:8]};
          sh_left_q <= sh_left_q - 4'h1;
          sh_first_q <= 1'b0;
        end
      end
      else if (cfg_pend_q & header_mode_i)
      begin
        // config frame goes ahead of the data it applies to
        sh_q <= {40'h0, 4'h0, range_ch_q, conf_ch_q, 2'b00, `GQ_HDR_CONFIG};
        sh_left_q <= `GQ_LEN_CONTROL;
        sh_first_q <= 1'b1;
        cfg_pend_q <= cfg_diff;
        range_ch_q <= 1'b0;
        conf_ch_q <= 1'b0;
      end
      else if (data_pend_q & ~q_tick)
      begin
        sh_q <= data_buf_q;
        sh_left_q <= data_len_q;
        sh_first_q <= 1'b1;
        data_pend_q <= 1'b0;
      end
    end
  end

  wire st_valid;
  wire [8:0] st_data;
  reg st_pop;
  assign stage_ready_o = st_ready;

  // burst reads stall the drain so the staging fifo absorbs frames
  stage_fifo #(
    .WIDTH(9),
    .DEPTH(STAGE_DEPTH),
    .AW(4)
  ) u_stage (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .flush_i(auto_flush),
    .in_valid_i(push),
    .in_ready_o(st_ready),
    .in_data_i({sh_first_q, sh_q[7:0]}),
    .out_valid_o(st_valid),
    .out_ready_i(st_pop),
    .out_data_o(st_data)
  );

  ////////////////////////////////////////////////////////////////////
  // byte queue: drain writer and host reader share one process
  reg [7:0] mem [0:QUEUE_BYTES-1];
  reg [`GQ_PTR_W-1:0] wptr_q;
  reg [`GQ_PTR_W-1:0] cptr_q;
  reg [`GQ_PTR_W-1:0] rptr_q;
  reg [3:0] fpos_q;
  reg [3:0] flen_q;
  reg [7:0] skip_q;
  reg [2:0] rd_st_q;
  reg [23:0] time_q;
  wire [7:0] old_byte = mem[cptr_q];
  wire [7:0] rd_byte = mem[rptr_q];
  wire [3:0] old_len = frame_len(header_mode_i, old_byte);
  wire [3:0] cur_len = (fpos_q == 4'h0) ? frame_len(header_mode_i, rd_byte) : flen_q;
  wire full_for_frame = (fill_count_o > QUEUE_BYTES - `GQ_MAX_FRAME);
  wire drain_ok = st_valid & ~burst_active_i & ~auto_flush;
  wire need_drop = drain_ok & st_data[8] & full_for_frame;
  wire queue_empty = (fill_count_o == {7'h0, fpos_q});

  always @*
  begin
    // reads own the pointer process, a pop then would lose the byte
    st_pop = drain_ok & ~need_drop & ~burst_start_i & ~rd_req_i;
  end

  always @(posedge sys_clk_i)
  begin
    if (st_pop)
      mem[wptr_q] <= st_data[7:0];
  end

  always @(posedge sys_clk_i)
  begin
    if (srst_i | auto_flush)
    begin
      wptr_q <= {`GQ_PTR_W{1'b0}};
      cptr_q <= {`GQ_PTR_W{1'b0}};
      rptr_q <= {`GQ_PTR_W{1'b0}};
      fill_count_o <= {`GQ_CNT_W{1'b0}};
      fpos_q <= 4'h0;
      flen_q <= 4'h0;
      skip_q <= 8'h00;
      overflow_o <= 1'b0;
      rd_st_q <= RD_DATA;
      time_q <= 24'h0;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_req_i;
      if (burst_start_i)
      begin
        // unfinished frame is repeated from its header
        rptr_q <= cptr_q;
        fpos_q <= 4'h0;
        rd_st_q <= (overflow_o & header_mode_i) ? RD_SKIP_HDR : RD_DATA;
      end
      else if (rd_req_i)
      begin
        case (rd_st_q)
          RD_SKIP_HDR:
          begin
            rd_data_o <= `GQ_HDR_SKIP;
            rd_st_q <= RD_SKIP_CNT;
          end
          RD_SKIP_CNT:
          begin
            rd_data_o <= skip_q;
            skip_q <= 8'h00;
            overflow_o <= 1'b0;
            rd_st_q <= RD_DATA;
          end
          RD_DATA:
          begin
            if (queue_empty)
            begin
              rd_data_o <= `GQ_PATTERN_EMPTY;
              time_q <= sensor_time_i;
              rd_st_q <= (header_mode_i & sensortime_frame_en_i) ? RD_TIME_HDR : RD_END;
              if (header_mode_i & sensortime_frame_en_i)
                rd_data_o <= `GQ_HDR_TIME;
            end
            else
            begin
              rd_data_o <= rd_byte;
              rptr_q <= rptr_q + 1'b1;
              flen_q <= cur_len;
              if (fpos_q + 4'h1 == cur_len)
              begin
                // whole frame read, commit its release
                cptr_q <= rptr_q + 1'b1;
                fill_count_o <= fill_count_o - {7'h0, cur_len};
                fpos_q <= 4'h0;
              end
              else
                fpos_q <= fpos_q + 4'h1;
            end
          end
          RD_TIME_HDR:
          begin
            rd_data_o <= time_q[7:0];
            rd_st_q <= RD_TIME_B0;
          end
          RD_TIME_B0:
          begin
            rd_data_o <= time_q[15:8];
            rd_st_q <= RD_TIME_B1;
          end
          RD_TIME_B1:
          begin
            rd_data_o <= time_q[23:16];
            rd_st_q <= RD_END;
          end
          default:
            rd_data_o <= `GQ_PATTERN_EMPTY;
        endcase
      end
      else if (need_drop)
      begin
        // drop the oldest frame to make room
        cptr_q <= cptr_q + {6'h0, old_len};
        fill_count_o <= fill_count_o - {7'h0, old_len};
        overflow_o <= 1'b1;
        if (skip_q != `GQ_SKIP_SAT)
          skip_q <= skip_q + 8'h01;
      end
      else if (st_pop)
      begin
        wptr_q <= wptr_q + 1'b1;
        fill_count_o <= fill_count_o + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### include/gyro_queue_defines.vh
`ifndef GYRO_QUEUE_DEFINES_VH
`define GYRO_QUEUE_DEFINES_VH
`define GQ_QUEUE_BYTES 1024
`define GQ_PTR_W 10
`define GQ_CNT_W 11
`define GQ_STAGE_DEPTH 16
`define GQ_CLK_HZ 100000000
`define GQ_BASE_RATE_HZ 6400
`define GQ_BASE_DIV (`GQ_CLK_HZ / `GQ_BASE_RATE_HZ)
`define GQ_MODE_NORMAL 3'h2
`define GQ_MODE_TWOFOLD 3'h1
`define GQ_MODE_FOURFOLD 3'h0
`define GQ_ODR_MIN 4'h6
`define GQ_ODR_MAX 4'hD
`define GQ_ODR_BASE 4'hE
`define GQ_ERR_NONE 4'h0
`define GQ_ERR_CONF 4'h1
`define GQ_KIND_REGULAR 2'h2
`define GQ_KIND_CONTROL 2'h1
`define GQ_PARAM_GYRO 4'h1
`define GQ_HDR_SKIP 8'h40
`define GQ_HDR_TIME 8'h44
`define GQ_HDR_CONFIG 8'h48
`define GQ_PATTERN_EMPTY 8'h80
`define GQ_SKIP_SAT 8'hFF
`define GQ_LEN_HEADERLESS 4'h6
`define GQ_LEN_REGULAR 4'h7
`define GQ_LEN_CONTROL 4'h2
`define GQ_MAX_FRAME 11'd7
`endif

// ### rtl/stage_fifo.v
`timescale 1ns/10ps
`default_nettype none
module stage_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire [AW:0] used = wr_q - rd_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // honest flags from the pointer distance
  assign in_ready_o = (used != DEPTH[AW:0]);
  assign out_valid_o = (used != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q[AW-1:0]];

  ////////////////////////////////////////////////////////////////////
  // pointers
  always @(posedge sys_clk_i)
  begin
    if (srst_i | flush_i)
    begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  // storage has no reset, contents are qualified by the pointers
  always @(posedge sys_clk_i)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data_i;
  end
endmodule
`default_nettype wire

// ### rtl/rate_divider.v
`timescale 1ns/10ps
`default_nettype none
module rate_divider #(
  parameter DIV = 15625,
  parameter CW = 14
) (
  input wire sys_clk_i,
  input wire srst_i,
  output reg tick_o
);
  reg [CW-1:0] cnt_q;

  // one-cycle enable every DIV clocks
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cnt_q <= {CW{1'b0}};
      tick_o <= 1'b0;
    end
    else if (cnt_q == DIV[CW-1:0] - 1'b1)
    begin
      cnt_q <= {CW{1'b0}};
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### bench/gyro_queue_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "gyro_queue_defines.vh"
module gyro_queue_chk #(
  parameter int BASE_DIV = 8,
  parameter int QUEUE_BYTES = 1024
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic power_normal_i,
  input wire logic [2:0] filter_mode_i,
  input wire logic [3:0] odr_sel_i,
  input wire logic header_mode_i,
  input wire logic queue_flush_i,
  input wire logic burst_active_i,
  input wire logic burst_start_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic sample_valid_o,
  input wire logic [3:0] err_code_o,
  input wire logic [`GQ_CNT_W-1:0] fill_count_o,
  input wire logic overflow_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////
  // read port: one answer per request, a cycle later
  a_read_answer: assert property (rd_req_i && !burst_start_i && !queue_flush_i
    && $stable(header_mode_i) |=> rd_valid_o) else $error("read not answered");
  a_valid_cause: assert property (rd_valid_o |-> $past(rd_req_i))
    else $error("answer without request");
  // headerless overread past committed data gives the empty pattern
  a_empty_pattern: assert property (!header_mode_i && $stable(header_mode_i)
    && burst_active_i && !queue_flush_i && fill_count_o == 0 && rd_req_i && !burst_start_i
    |=> rd_data_o == `GQ_PATTERN_EMPTY) else $error("overread pattern wrong");
  // skip frame leads the burst after an overflow in header mode
  a_skip_first: assert property (burst_start_i && header_mode_i && overflow_o
    ##1 rd_req_i |=> rd_data_o == `GQ_HDR_SKIP) else $error("skip header missing");
  a_fill_bound: assert property (fill_count_o <= QUEUE_BYTES)
    else $error("fill count above capacity");
  ////////////////////////////////////////////////////////////////////////
  // configuration checks, one cycle of lag
  a_mode_error: assert property (filter_mode_i > `GQ_MODE_NORMAL
    |=> err_code_o == `GQ_ERR_CONF) else $error("illegal mode not flagged");
  a_rate_error: assert property ((odr_sel_i < `GQ_ODR_MIN || odr_sel_i > `GQ_ODR_MAX)
    |=> err_code_o == `GQ_ERR_CONF) else $error("illegal rate not flagged");
  a_legal_clean: assert property (filter_mode_i <= `GQ_MODE_NORMAL
    && odr_sel_i >= `GQ_ODR_MIN && odr_sel_i <= `GQ_ODR_MAX |=> err_code_o == `GQ_ERR_NONE)
    else $error("legal setting flagged");
  // no processing while asleep; updates at least five clocks apart
  a_sleep_quiet: assert property ((!power_normal_i) [*3] |-> !sample_valid_o)
    else $error("sample while asleep");
  a_sample_space: assert property (sample_valid_o |=> !sample_valid_o [*4])
    else $error("samples too close");
  c_overflow: cover property ($rose(overflow_o));
  c_overread: cover property (rd_valid_o && rd_data_o == `GQ_PATTERN_EMPTY);
  c_time_frame: cover property (rd_valid_o && rd_data_o == `GQ_HDR_TIME);
  c_sample: cover property (sample_valid_o);
endmodule
bind gyro_filter_and_frame_queue gyro_queue_chk #(.BASE_DIV(BASE_DIV), .QUEUE_BYTES(QUEUE_BYTES))
  u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .power_normal_i(power_normal_i),
  .filter_mode_i(filter_mode_i), .odr_sel_i(odr_sel_i), .header_mode_i(header_mode_i),
  .queue_flush_i(queue_flush_i), .burst_active_i(burst_active_i), .burst_start_i(burst_start_i),
  .rd_req_i(rd_req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .sample_valid_o(sample_valid_o), .err_code_o(err_code_o), .fill_count_o(fill_count_o),
  .overflow_o(overflow_o));
`default_nettype wire

// ### bench/queue_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module queue_host_model (
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic [10:0] n_bytes_i,
  output logic busy_o,
  output logic burst_active_o,
  output logic burst_start_o,
  output logic rd_req_o
);
  // one burst per go: start pulse, then back-to-back byte requests
  initial
  begin
    busy_o = 1'b0;
    burst_active_o = 1'b0;
    burst_start_o = 1'b0;
    rd_req_o = 1'b0;
    forever
    begin
      @(posedge sys_clk_i);
      if (go_i === 1'b1)
      begin
        #1;
        busy_o = 1'b1;
        burst_active_o = 1'b1;
        burst_start_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        burst_start_o = 1'b0;
        rd_req_o = (n_bytes_i != 11'h000);
        repeat (n_bytes_i) @(posedge sys_clk_i);
        #1;
        rd_req_o = 1'b0;
        // hold the burst until the last answer has landed
        repeat (3) @(posedge sys_clk_i);
        #1;
        burst_active_o = 1'b0;
        busy_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/gyro_filter_and_frame_queue_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "gyro_queue_defines.vh"
`define CHK(got, exp) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (exp)) \
    begin \
      miscompares = miscompares + 1; \
      $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module gyro_filter_and_frame_queue_tb;
  logic sys_clk_i, srst_i, power_normal_i, header_mode_i, pin_tag_en_i, queue_flush_i;
  logic sensortime_frame_en_i, interrupt_line_1, interrupt_line_2, go, busy, b_act, b_start;
  logic rd_req, prefilt_sel, stage_ready;
  logic [1:0] gyro_range;
  logic [2:0] filter_mode_i, queue_decimation_i;
  logic [3:0] odr_sel_i, err_code_o;
  logic [47:0] raw_v, sample_o;
  logic [23:0] stime;
  logic [10:0] n_bytes, fill;
  logic [7:0] rd_data_o, exp_b, hdr;
  logic [15:0] lfsr_q;
  logic rd_valid_o, sample_valid_o, overflow_o;
  logic [`GQ_CNT_W-1:0] fill_count_o;
  logic [7:0] exp_q[$];
  int miscompares, check_count, cnt;
  gyro_filter_and_frame_queue #(.BASE_DIV(8)) u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .power_normal_i(power_normal_i), .filter_mode_i(filter_mode_i), .odr_sel_i(odr_sel_i),
    .gyro_range_i(gyro_range), .queue_decimation_i(queue_decimation_i),
    .prefilt_sel_i(prefilt_sel),
    .header_mode_i(header_mode_i), .queue_gyro_en_i(1'b1),
    .sensortime_frame_en_i(sensortime_frame_en_i), .pin_tag_en_i(pin_tag_en_i),
    .interrupt_line_1_i(interrupt_line_1), .interrupt_line_2_i(interrupt_line_2),
    .raw_sample_i(raw_v),
    .sensor_time_i(stime), .queue_flush_i(queue_flush_i), .burst_active_i(b_act),
    .burst_start_i(b_start), .rd_req_i(rd_req), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .sample_o(sample_o), .sample_valid_o(sample_valid_o), .err_code_o(err_code_o),
    .fill_count_o(fill_count_o), .overflow_o(overflow_o), .stage_ready_o(stage_ready));
  queue_host_model u_host (.sys_clk_i(sys_clk_i), .go_i(go), .n_bytes_i(n_bytes),
    .busy_o(busy), .burst_active_o(b_act), .burst_start_o(b_start), .rd_req_o(rd_req));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // frame bytes follow the sample register order: x, y, z, low byte first
  task automatic push_frame(input logic with_hdr);
    if (with_hdr)
      exp_q.push_back(hdr);
    for (int i = 0; i < 6; i++)
      exp_q.push_back(raw_v[8*i +: 8]);
  endtask
  // host burst of n bytes, bounded wait on the partner
  task automatic burst(input logic [10:0] n);
    n_bytes = n;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(1);
    for (int i = 0; i < 3000 && busy === 1'b1; i++)
      cyc(1);
    `CHK(exp_q.size(), 0)
  endtask
  task automatic stop_and_fill();
    power_normal_i = 1'b0;
    cyc(40);
    fill = fill_count_o;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // read answers taken off the expectation queue in order
  always @(posedge sys_clk_i)
  begin
    if (rd_valid_o === 1'b1)
    begin
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(rd_data_o, exp_b)
    end
  end
  // hang guard, well above the expected run length
  initial
  begin
    repeat (40000) @(posedge sys_clk_i);
    miscompares = miscompares + 1;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    miscompares = 0;
    check_count = 0;
    lfsr_q = 16'h0016;
    for (int i = 0; i < 3; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      raw_v[16*i +: 16] = lfsr_q;
    end
    stime = {lfsr_q[7:0], lfsr_q};
    {interrupt_line_2, interrupt_line_1} = lfsr_q[1:0];
    gyro_range = 2'h0;
    prefilt_sel = 1'b1;
    srst_i = 1'b1;
    power_normal_i = 1'b1;
    filter_mode_i = `GQ_MODE_NORMAL;
    odr_sel_i = 4'hD;
    queue_decimation_i = 3'h1;
    header_mode_i = 1'b0;
    pin_tag_en_i = 1'b1;
    sensortime_frame_en_i = 1'b1;
    queue_flush_i = 1'b0;
    go = 1'b0;
    n_bytes = 11'h000;
    cyc(10);
    `CHK(rd_valid_o, 1'b0)
    `CHK(fill_count_o, 11'h000)
    `CHK(stage_ready, 1'b1)
    srst_i = 1'b0;
    cyc(1);
    // every mode and rate code against the legal set
    for (int m = 0; m < 8; m++)
      for (int r = 0; r < 16; r++)
      begin
        filter_mode_i = m[2:0];
        odr_sel_i = r[3:0];
        cyc(2);
        `CHK(err_code_o, (m <= 2 && r >= 6 && r <= 13) ? `GQ_ERR_NONE : `GQ_ERR_CONF)
      end
    odr_sel_i = 4'hD;
    // each filter mode: update count at 3200 Hz and the averaged value
    for (int m = 2; m >= 0; m--)
    begin
      filter_mode_i = m[2:0];
      cyc(200);
      cnt = 0;
      for (int i = 0; i < 320; i++)
      begin
        cyc(1);
        cnt += (sample_valid_o === 1'b1);
      end
      `CHK(cnt >= 19 && cnt <= 21, 1'b1)
      `CHK(sample_o, raw_v)
    end
    // asleep: no updates, queue stops growing
    stop_and_fill();
    cnt = 0;
    for (int i = 0; i < 320; i++)
    begin
      cyc(1);
      cnt += (sample_valid_o === 1'b1);
    end
    `CHK(cnt, 0)
    `CHK(fill_count_o, fill)
    `CHK(fill % 6, 0)
    for (int i = 0; i < fill / 6; i++)
      push_frame(1'b0);
    repeat (6) exp_q.push_back(`GQ_PATTERN_EMPTY);
    burst(fill + 11'd6);
    // header mode with pin tags, then time frame and end marker on overread
    header_mode_i = 1'b1;
    power_normal_i = 1'b1;
    cyc(300);
    stop_and_fill();
    `CHK(fill % 7, 0)
    hdr = {`GQ_KIND_REGULAR, `GQ_PARAM_GYRO, interrupt_line_2, interrupt_line_1};
    for (int i = 0; i < fill / 7; i++)
      push_frame(1'b1);
    exp_q.push_back(`GQ_HDR_TIME);
    for (int i = 0; i < 3; i++)
      exp_q.push_back(stime[8*i +: 8]);
    exp_q.push_back(`GQ_PATTERN_EMPTY);
    burst(fill + 11'd5);
    // overflow: oldest data overwritten, skip frame saturated ahead of data
    pin_tag_en_i = 1'b0;
    power_normal_i = 1'b1;
    queue_flush_i = 1'b1;
    cyc(1);
    queue_flush_i = 1'b0;
    cyc(10000);
    stop_and_fill();
    `CHK(overflow_o, 1'b1)
    hdr = {`GQ_KIND_REGULAR, `GQ_PARAM_GYRO, 2'h0};
    exp_q.push_back(`GQ_HDR_SKIP);
    exp_q.push_back(`GQ_SKIP_SAT);
    push_frame(1'b1);
    push_frame(1'b1);
    burst(11'd16);
    `CHK(overflow_o, 1'b0)
    // range and source change: config frame first, then frames at half the output rate
    queue_flush_i = 1'b1;
    cyc(1);
    queue_flush_i = 1'b0;
    gyro_range = 2'h1;
    prefilt_sel = 1'b0;
    power_normal_i = 1'b1;
    cyc(320);
    stop_and_fill();
    `CHK(fill >= 11'd65 && fill <= 11'd79, 1'b1)
    exp_q.push_back(`GQ_HDR_CONFIG);
    exp_q.push_back(8'h0C);
    for (int i = 0; i < (fill - 11'd2) / 7; i++)
      push_frame(1'b1);
    burst(fill);
    print_verdict();
  end
endmodule
`default_nettype wire
